// *** dts_top.sv ***
// Debug trace status block: control, run tracking, status and interrupt registers.
// Assumes synchronous comparator match pulses and trace FIFO push/pop strobes.
`default_nettype none
module dts_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        match_a_i,
  input  wire logic        match_b_i,
  input  wire logic        fifo_push_i,
  input  wire logic        fifo_pop_i,
  output logic             run_active_o,
  output logic             irq_o
);
  typedef struct packed {
    dts_pkg::dts_state_t    state;
    logic                   run;
    logic                   enable;
    logic                   arm;
    logic                   end_mode;
    logic                   match_a;
    logic                   match_b;
    logic [3:0]             count;
    logic [dts_pkg::IRQ_W-1:0] irq_st;
    logic [dts_pkg::IRQ_W-1:0] irq_msk;
    logic [31:0]            dat;
    logic                   ack;
    logic                   irq;
  } dts_regs_t;

  dts_regs_t cur_ff;
  dts_regs_t nxt_ff;

  logic       acc;
  logic       wr_ctl;
  logic [7:0] status;
  logic       trigger;
  logic       stop_sw;
  logic       ends;
  logic       starts;
  logic [3:0] cnt_next;

  assign acc     = wb_cyc_i && wb_stb_i && !cur_ff.ack;
  assign wr_ctl  = acc && wb_we_i && wb_sel_i[0] && (wb_adr_i == dts_pkg::ADDR_CONTROL);
  assign trigger = match_a_i || match_b_i;

  always_comb begin
    status = 8'h00;
    status[dts_pkg::BIT_MATCH_A] = cur_ff.match_a;
    status[dts_pkg::BIT_MATCH_B] = cur_ff.match_b;
    status[dts_pkg::BIT_ARMED]   = cur_ff.enable && cur_ff.arm;
    status[dts_pkg::CNT_MSB:0]   = cur_ff.count;
  end

  always_comb begin
    nxt_ff   = cur_ff;
    stop_sw  = 1'b0;
    starts   = 1'b0;
    ends     = 1'b0;
    cnt_next = cur_ff.count;
    nxt_ff.ack = acc;
    nxt_ff.dat = 32'h0000_0000;
    if (wr_ctl) begin
      nxt_ff.enable   = wb_dat_i[dts_pkg::CTL_ENABLE];
      nxt_ff.arm      = wb_dat_i[dts_pkg::CTL_ARM];
      nxt_ff.end_mode = wb_dat_i[dts_pkg::CTL_END_MODE];
      stop_sw = !wb_dat_i[dts_pkg::CTL_ENABLE] || !wb_dat_i[dts_pkg::CTL_ARM];
      starts  = wb_dat_i[dts_pkg::CTL_ENABLE] && wb_dat_i[dts_pkg::CTL_ARM];
    end
    // Push counting saturates at depth; pops are deliberately not looked at
    if (cur_ff.state == dts_pkg::DTS_RUN && fifo_push_i && cur_ff.count != dts_pkg::FIFO_DEPTH)
      cnt_next = cur_ff.count + dts_pkg::CNT_ONE;
    unique case (cur_ff.state)
      dts_pkg::DTS_IDLE: begin
        if (starts) begin
          nxt_ff.state   = dts_pkg::DTS_RUN;
          nxt_ff.match_a = 1'b0;
          nxt_ff.match_b = 1'b0;
          nxt_ff.count   = dts_pkg::CNT_ZERO;
        end
      end
      dts_pkg::DTS_RUN: begin
        nxt_ff.count = cnt_next;
        if (match_a_i) nxt_ff.match_a = 1'b1;
        if (match_b_i) nxt_ff.match_b = 1'b1;
        if (stop_sw) begin
          ends = 1'b1;
        end else if (!cur_ff.end_mode && cnt_next == dts_pkg::FIFO_DEPTH) begin
          ends = 1'b1;
        end else if (cur_ff.end_mode && trigger) begin
          ends = 1'b1;
        end
        if (ends) begin
          nxt_ff.state = dts_pkg::DTS_IDLE;
          nxt_ff.arm   = 1'b0;
        end
      end
    endcase
    // Read of the interrupt status clears it, but a new event in the same cycle wins
    if (acc && !wb_we_i && wb_adr_i == dts_pkg::ADDR_IRQ_ST)
      nxt_ff.irq_st = '0;
    if (ends) nxt_ff.irq_st[dts_pkg::IRQ_RUN_END] = 1'b1;
    if (cur_ff.state == dts_pkg::DTS_RUN && match_a_i) nxt_ff.irq_st[dts_pkg::IRQ_MATCH_A] = 1'b1;
    if (cur_ff.state == dts_pkg::DTS_RUN && match_b_i) nxt_ff.irq_st[dts_pkg::IRQ_MATCH_B] = 1'b1;
    if (acc && wb_we_i && wb_sel_i[0] && wb_adr_i == dts_pkg::ADDR_IRQ_MSK)
      nxt_ff.irq_msk = wb_dat_i[dts_pkg::IRQ_W-1:0];
    if (acc && !wb_we_i) begin
      unique case (wb_adr_i)
        dts_pkg::ADDR_STATUS:  nxt_ff.dat = {24'h00_0000, status};
        dts_pkg::ADDR_CONTROL: nxt_ff.dat = {24'h00_0000, cur_ff.enable, cur_ff.arm,
                                             5'h00, cur_ff.end_mode};
        dts_pkg::ADDR_IRQ_ST:  nxt_ff.dat = {29'h0000_0000, cur_ff.irq_st};
        dts_pkg::ADDR_IRQ_MSK: nxt_ff.dat = {29'h0000_0000, cur_ff.irq_msk};
        default:               nxt_ff.dat = 32'h0000_0000;
      endcase
    end
    nxt_ff.irq = |(nxt_ff.irq_st & nxt_ff.irq_msk);
    // Registered copy of the state, so the run output leaves a flop directly
    nxt_ff.run = nxt_ff.state == dts_pkg::DTS_RUN;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign wb_dat_o     = cur_ff.dat;
  assign wb_ack_o     = cur_ff.ack;
  assign run_active_o = cur_ff.run;
  assign irq_o        = cur_ff.irq;

  property p_status_ro;
    @(posedge clk_i) disable iff (rst_i)
    (acc && wb_we_i && wb_adr_i == dts_pkg::ADDR_STATUS && cur_ff.state == dts_pkg::DTS_IDLE)
      |=> $stable(status);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed by write");

  property p_match_a;
    @(posedge clk_i) disable iff (rst_i)
    (run_active_o && match_a_i) |=> status[dts_pkg::BIT_MATCH_A];
  endproperty
  a_match_a: assert property (p_match_a) else $error("match A flag not set");

  property p_match_b;
    @(posedge clk_i) disable iff (rst_i)
    (run_active_o && match_b_i) |=> status[dts_pkg::BIT_MATCH_B];
  endproperty
  a_match_b: assert property (p_match_b) else $error("match B flag not set");

  property p_armed_mirror;
    @(posedge clk_i) disable iff (rst_i)
    cur_ff.enable |-> status[dts_pkg::BIT_ARMED] == cur_ff.arm;
  endproperty
  a_armed_mirror: assert property (p_armed_mirror) else $error("armed bit mismatch");

  sequence s_start;
    !run_active_o && wr_ctl && starts;
  endsequence
  property p_start;
    @(posedge clk_i) disable iff (rst_i)
    s_start |=> run_active_o && status[dts_pkg::BIT_ARMED] && cur_ff.count == dts_pkg::CNT_ZERO;
  endproperty
  a_start: assert property (p_start) else $error("run start wrong");

  property p_full_end;
    @(posedge clk_i) disable iff (rst_i)
    (run_active_o && !cur_ff.end_mode && cnt_next == dts_pkg::FIFO_DEPTH) |=> !run_active_o;
  endproperty
  a_full_end: assert property (p_full_end) else $error("run kept past full");

  property p_trig_end;
    @(posedge clk_i) disable iff (rst_i)
    (run_active_o && cur_ff.end_mode && trigger && !wr_ctl) |=> !run_active_o && !cur_ff.arm;
  endproperty
  a_trig_end: assert property (p_trig_end) else $error("trigger did not end run");

  property p_sw_stop;
    @(posedge clk_i) disable iff (rst_i)
    (run_active_o && wr_ctl && stop_sw) |=> !run_active_o;
  endproperty
  a_sw_stop: assert property (p_sw_stop) else $error("software stop ignored");

  property p_cnt_range;
    @(posedge clk_i) disable iff (rst_i)
    cur_ff.count <= dts_pkg::FIFO_DEPTH;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("count out of range");

  property p_pop_keeps;
    @(posedge clk_i) disable iff (rst_i)
    (fifo_pop_i && !fifo_push_i && !wr_ctl) |=> $stable(cur_ff.count);
  endproperty
  a_pop_keeps: assert property (p_pop_keeps) else $error("pop changed count");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
    (!run_active_o && !wr_ctl) |=> $stable(cur_ff.count) && $stable(cur_ff.match_a)
      && $stable(cur_ff.match_b);
  endproperty
  a_hold: assert property (p_hold) else $error("idle state changed");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held past one cycle");

  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

  property p_dat_quiet;
    @(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_dat_quiet: assert property (p_dat_quiet) else $error("read data outside ack");

  property p_status_read;
    @(posedge clk_i) disable iff (rst_i)
    (acc && !wb_we_i && wb_adr_i == dts_pkg::ADDR_STATUS)
      |=> wb_dat_o == {24'h00_0000, $past(status)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  sequence s_run_end;
    run_active_o ##1 !run_active_o;
  endsequence

  property p_end_disarms;
    @(posedge clk_i) disable iff (rst_i)
    s_run_end |-> !cur_ff.arm && !status[dts_pkg::BIT_ARMED];
  endproperty
  a_end_disarms: assert property (p_end_disarms) else $error("armed flag left set");

  property p_end_flagged;
    @(posedge clk_i) disable iff (rst_i)
    s_run_end |-> cur_ff.irq_st[dts_pkg::IRQ_RUN_END];
  endproperty
  a_end_flagged: assert property (p_end_flagged) else $error("run end not flagged");

  property p_start_clears;
    @(posedge clk_i) disable iff (rst_i)
    s_start |=> !status[dts_pkg::BIT_MATCH_A] && !status[dts_pkg::BIT_MATCH_B];
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("flags kept at start");

  property p_flag_a_holds;
    @(posedge clk_i) disable iff (rst_i)
    (run_active_o && cur_ff.match_a) |=> cur_ff.match_a;
  endproperty
  a_flag_a_holds: assert property (p_flag_a_holds) else $error("match A flag lost");

  property p_flag_b_holds;
    @(posedge clk_i) disable iff (rst_i)
    (run_active_o && cur_ff.match_b) |=> cur_ff.match_b;
  endproperty
  a_flag_b_holds: assert property (p_flag_b_holds) else $error("match B flag lost");

  property p_run_armed;
    @(posedge clk_i) disable iff (rst_i)
    run_active_o |-> cur_ff.enable && cur_ff.arm;
  endproperty
  a_run_armed: assert property (p_run_armed) else $error("run without enable and arm");

  property p_count_step;
    @(posedge clk_i) disable iff (rst_i)
    (run_active_o && fifo_push_i && cur_ff.count != dts_pkg::FIFO_DEPTH)
      |=> cur_ff.count == $past(cur_ff.count) + dts_pkg::CNT_ONE;
  endproperty
  a_count_step: assert property (p_count_step) else $error("push not counted");

  property p_irq_read_clears;
    @(posedge clk_i) disable iff (rst_i)
    (acc && !wb_we_i && wb_adr_i == dts_pkg::ADDR_IRQ_ST && !run_active_o)
      |=> cur_ff.irq_st == '0 && !irq_o;
  endproperty
  a_irq_read_clears: assert property (p_irq_read_clears) else $error("irq status not cleared");

  property p_irq_set_wins;
    @(posedge clk_i) disable iff (rst_i)
    (run_active_o && match_a_i) |=> cur_ff.irq_st[dts_pkg::IRQ_MATCH_A];
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins) else $error("match A event lost");
endmodule
`default_nettype wire

// *** dts_pkg.sv ***
// Package for the debug trace status block: register map, field layout, constants.
// Assumes a 32-bit classic Wishbone bus with byte addresses, one register per word.
package dts_pkg;
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h0C;
  localparam int         BIT_MATCH_A  = 7;
  localparam int         BIT_MATCH_B  = 6;
  localparam int         BIT_ARMED    = 5;
  localparam int         CNT_MSB      = 3;
  localparam int         CTL_ENABLE   = 7;
  localparam int         CTL_ARM      = 6;
  localparam int         CTL_END_MODE = 0;
  localparam logic [3:0] FIFO_DEPTH   = 4'h8;
  localparam logic [3:0] CNT_ZERO     = 4'h0;
  localparam logic [3:0] CNT_ONE      = 4'h1;
  localparam int         IRQ_W        = 3;
  localparam int         IRQ_RUN_END  = 0;
  localparam int         IRQ_MATCH_A  = 1;
  localparam int         IRQ_MATCH_B  = 2;
  typedef enum logic [0:0] {DTS_IDLE, DTS_RUN} dts_state_t;
endpackage

// *** dts_host_model.sv ***
// Model of the external debug host and trace source facing the block.
// Assumes one clock; strobes change by non-blocking assignment after an edge.
`default_nettype none
module dts_host_model (
  input  wire logic clk_i,
  output logic      fifo_push_o,
  output logic      fifo_pop_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int tally = 0;
  initial begin
    fifo_push_o = 1'b0;
    fifo_pop_o  = 1'b0;
  end
  task automatic push(input int n);
    repeat (n) begin
      @(posedge clk_i);
      fifo_push_o <= 1'b1;
      tally++;
    end
    @(posedge clk_i);
    fifo_push_o <= 1'b0;
  endtask
  // The block never counts down, so the host keeps its own tally
  task automatic drain();
    while (tally > 0) begin
      @(posedge clk_i);
      fifo_pop_o <= 1'b1;
      tally--;
    end
    @(posedge clk_i);
    fifo_pop_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** test_dts_top.sv ***
// Self-checking bench for the debug trace status block.
// Assumes dts_pkg, dts_top and dts_host_model are compiled first.
`default_nettype none
module test_dts_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, cyc, stb, we, ma, mb, ack, act, irq, push, pop;
  logic [7:0]  adr;
  logic [3:0]  sel, wsel;
  logic [31:0] wdat, rdat, dout;
  int          num_errors = 0;
  int          n_checks = 0;
  dts_top dts_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout),
    .wb_ack_o(ack), .match_a_i(ma), .match_b_i(mb), .fifo_push_i(push),
    .fifo_pop_i(pop), .run_active_o(act), .irq_o(irq));
  dts_host_model dts_host_model_inst (.clk_i(clk_i), .fifo_push_o(push), .fifo_pop_o(pop));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", s, exp, got);
    end
  endtask
  // Two idle cycles first let run-end and status updates settle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    repeat (2) @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= wsel;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      wrap_up();
    end
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
    wb(1'b0, a, 32'h0000_0000);
    chk(s, rdat, e);
  endtask
  task automatic hit(input logic b);
    ma <= !b;
    mb <= b;
    @(posedge clk_i);
    ma <= 1'b0;
    mb <= 1'b0;
  endtask
  task automatic t_begin_mode();
    rd(8'h10, 32'h0000_0000, "unmapped");
    wb(1'b1, dts_pkg::ADDR_CONTROL, 32'h0000_00C0);
    rd(dts_pkg::ADDR_STATUS, 32'h0000_0020, "armed");
    chk("active", {31'h0, act}, 32'h0000_0001);
    hit(1'b0);
    dts_host_model_inst.push(8);
    rd(dts_pkg::ADDR_STATUS, 32'h0000_0088, "full");
    chk("active", {31'h0, act}, 32'h0000_0000);
    wb(1'b1, dts_pkg::ADDR_STATUS, 32'h0000_00FF);
    rd(dts_pkg::ADDR_STATUS, 32'h0000_0088, "ro");
    dts_host_model_inst.drain();
    rd(dts_pkg::ADDR_STATUS, 32'h0000_0088, "drained");
    $display("begin-trace test done");
  endtask
  task automatic t_end_mode();
    wb(1'b1, dts_pkg::ADDR_CONTROL, 32'h0000_00C1);
    rd(dts_pkg::ADDR_STATUS, 32'h0000_0020, "restart");
    dts_host_model_inst.push(3);
    hit(1'b1);
    rd(dts_pkg::ADDR_STATUS, 32'h0000_0043, "trigger");
    chk("active", {31'h0, act}, 32'h0000_0000);
    $display("end-trace test done");
  endtask
  task automatic t_manual_end();
    logic [31:0] v [2];
    v = '{32'h0000_0080, 32'h0000_0040};
    foreach (v[i]) begin
      wb(1'b1, dts_pkg::ADDR_CONTROL, 32'h0000_00C0);
      dts_host_model_inst.push(2);
      wb(1'b1, dts_pkg::ADDR_CONTROL, v[i]);
      rd(dts_pkg::ADDR_STATUS, 32'h0000_0002, "manual");
      chk("active", {31'h0, act}, 32'h0000_0000);
    end
    $display("manual end test done");
  endtask
  task automatic t_irq();
    chk("masked irq", {31'h0, irq}, 32'h0000_0000);
    wb(1'b1, dts_pkg::ADDR_IRQ_MSK, 32'h0000_0007);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    rd(dts_pkg::ADDR_IRQ_ST, 32'h0000_0007, "irq status");
    rd(dts_pkg::ADDR_IRQ_ST, 32'h0000_0000, "irq cleared");
    chk("irq low", {31'h0, irq}, 32'h0000_0000);
    $display("interrupt test done");
  endtask
  task automatic t_reset_mid();
    wb(1'b1, dts_pkg::ADDR_CONTROL, 32'h0000_00C0);
    hit(1'b0);
    dts_host_model_inst.push(1);
    chk("irq before reset", {31'h0, irq}, 32'h0000_0001);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("active after reset", {31'h0, act}, 32'h0000_0000);
    chk("irq after reset", {31'h0, irq}, 32'h0000_0000);
    rd(dts_pkg::ADDR_STATUS, 32'h0000_0000, "status after reset");
    // A write with its low byte lane off must leave the control register alone
    wsel = 4'h0;
    wb(1'b1, dts_pkg::ADDR_CONTROL, 32'h0000_00C0);
    wsel = 4'hF;
    rd(dts_pkg::ADDR_CONTROL, 32'h0000_0000, "unselected write");
    $display("mid-run reset test done");
  endtask
  initial begin
    {cyc, stb, we, ma, mb} = 5'h00;
    adr   = 8'h00;
    sel   = 4'h0;
    wsel  = 4'hF;
    wdat  = 32'h0000_0000;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(dts_pkg::ADDR_STATUS, 32'h0000_0000, "reset status");
    t_begin_mode();
    t_end_mode();
    t_manual_end();
    t_irq();
    t_reset_mid();
    wrap_up();
  end
endmodule
`default_nettype wire
